/* core/cpg_counter_pulse.sv */
// The implementer's own choices: the APB slave port and the placing of the registers.
module cpg_counter_pulse
   import cpg_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_n,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Counter inputs.
   input  wire logic        countSource,
   input  wire logic        gateIn,
   input  wire logic        hardware_arm_input,
   // Counter and generator outputs.
   output logic             counterOut,
   output logic             terminal_count_event,
   output logic             square_wave_generator_out,
   output logic             sampleClkDo,
   output logic             sampleClkDi,
   // Function pins carrying counter out, gate copy and square wave.
   output logic [2:0]       programmable_function_pin,
   output logic [2:0]       programmable_function_pin_oe
);
   import cpg_pkg::*;

   logic [31:0] ctrl_r, delay_r, high_r, low_r;
   logic [7:0]  incr_r;
   logic [5:0]  fgen_r;
   logic [2:0]  pinEn_r;
   logic        armed_r;
   logic        srcPrev_r, gatePrev_r, hwPrev_r;
   logic        srcEdge, gateEdge, gateLvl, hwArmEdge;
   cpg_state_t  state_r;
   logic [31:0] cnt_r, curDelay_r;
   logic        trigUsed_r, tcPulse, level_r, sqWave;
   logic        wrEn, rdEn, armCmd, disarmCmd;
   logic        pauseNow, finGate_r;
   cpg_mode_t   mode;

   assign mode     = cpg_mode_t'(ctrl_r[CPG_CTRL_MODE_LSB +: 3]);
   assign wrEn     = psel && penable && pwrite;
   assign rdEn     = psel && penable && !pwrite;
   assign armCmd   = wrEn && paddr == CPG_OFF_CMD && pwdata[CPG_CMD_ARM];
   assign disarmCmd = wrEn && paddr == CPG_OFF_CMD && pwdata[CPG_CMD_DISARM];

   // Edge detection on inputs that are taken as synchronous to clk.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         srcPrev_r  <= 1'b0;
         gatePrev_r <= 1'b0;
         hwPrev_r   <= 1'b0;
      end else begin
         srcPrev_r  <= countSource;
         gatePrev_r <= gateIn;
         hwPrev_r   <= hardware_arm_input;
      end
   end
   assign srcEdge = ctrl_r[CPG_CTRL_SRCFALL] ? (srcPrev_r && !countSource)
                                             : (!srcPrev_r && countSource);
   assign gateEdge = ctrl_r[CPG_CTRL_GATEFALL] ? (gatePrev_r && !gateIn)
                                               : (!gatePrev_r && gateIn);
   assign gateLvl  = gateIn ^ ctrl_r[CPG_CTRL_PAUSELVL];
   assign hwArmEdge = !hwPrev_r && hardware_arm_input;
   // Finite train: an internal single pulse gates the train as a pause level.
   assign pauseNow = ctrl_r[CPG_CTRL_FINITE] ? !finGate_r
                   : (ctrl_r[CPG_CTRL_PAUSE] && !ctrl_r[CPG_CTRL_STARTTRIG] && gateLvl);

   // APB registers; zero wait states, unmapped reads give zero with an error.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r  <= CPG_RST_CTRL;
         delay_r <= CPG_RST_COUNT;
         high_r  <= CPG_RST_COUNT;
         low_r   <= CPG_RST_COUNT;
         incr_r  <= CPG_RST_INCR;
         fgen_r  <= CPG_RST_FGEN;
         pinEn_r <= CPG_RST_PINS;
      end else if (wrEn) begin
         case (paddr)
            CPG_OFF_CTRL:  ctrl_r  <= pwdata;
            CPG_OFF_DELAY: delay_r <= pwdata;
            CPG_OFF_HIGH:  high_r  <= pwdata;
            CPG_OFF_LOW:   low_r   <= pwdata;
            CPG_OFF_INCR:  incr_r  <= pwdata[7:0];
            CPG_OFF_FGEN:  fgen_r  <= pwdata[5:0];
            CPG_OFF_PINS:  pinEn_r <= pwdata[2:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && !penable) begin
            case (paddr)
               CPG_OFF_CTRL:   prdata <= ctrl_r;
               CPG_OFF_DELAY:  prdata <= delay_r;
               CPG_OFF_HIGH:   prdata <= high_r;
               CPG_OFF_LOW:    prdata <= low_r;
               CPG_OFF_INCR:   prdata <= {24'h00_0000, incr_r};
               CPG_OFF_FGEN:   prdata <= {26'h000_0000, fgen_r};
               CPG_OFF_STATUS: prdata <= {26'h000_0000, trigUsed_r, level_r, armed_r,
                                          state_r};
               CPG_OFF_CMD:    prdata <= 32'h0000_0000;
               CPG_OFF_PINS:   prdata <= {29'h0000_0000, pinEn_r};
               default:        pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Arming by software or by the hardware arm input, when selected.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_r <= 1'b0;
      end else if (disarmCmd) begin
         armed_r <= 1'b0;
      end else if (armCmd || (ctrl_r[CPG_CTRL_HWARM] && hwArmEdge)) begin
         armed_r <= 1'b1;
      end
   end

   // Main sequencer. Counts reach terminal count when cnt_r is 1 or 0 on an active edge.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r    <= CPG_S_IDLE;
         cnt_r      <= 32'h0000_0000;
         curDelay_r <= 32'h0000_0000;
         trigUsed_r <= 1'b0;
         tcPulse    <= 1'b0;
      end else begin
         tcPulse <= 1'b0;
         if (!armed_r || disarmCmd) begin
            state_r    <= CPG_S_IDLE;
            trigUsed_r <= 1'b0;
         end else begin
            case (state_r)
               CPG_S_IDLE: begin
                  curDelay_r <= delay_r;
                  cnt_r      <= delay_r;
                  if (mode == CPG_M_SINGLE ||
                      (mode == CPG_M_TRAIN && !ctrl_r[CPG_CTRL_STARTTRIG])) begin
                     state_r <= CPG_S_DELAY;
                  end else begin
                     state_r <= CPG_S_WAIT;
                  end
               end
               CPG_S_WAIT: begin
                  // Gate edges only count here, so edges during a pulse are lost.
                  if (gateEdge) begin
                     trigUsed_r <= 1'b1;
                     cnt_r      <= (mode == CPG_M_GROW) ? curDelay_r : delay_r;
                     state_r    <= CPG_S_DELAY;
                  end
               end
               CPG_S_DELAY: begin
                  if (srcEdge && !(mode == CPG_M_TRAIN && pauseNow)) begin
                     if (cnt_r <= 32'h0000_0001) begin
                        tcPulse <= 1'b1;
                        cnt_r   <= high_r;
                        state_r <= CPG_S_HIGH;
                     end else begin
                        cnt_r <= cnt_r - 32'h0000_0001;
                     end
                  end
               end
               CPG_S_HIGH: begin
                  if (srcEdge && !(mode == CPG_M_TRAIN && pauseNow)) begin
                     if (cnt_r <= 32'h0000_0001) begin
                        tcPulse <= 1'b1;
                        if (mode == CPG_M_TRAIN) begin
                           cnt_r   <= low_r;
                           state_r <= CPG_S_LOW;
                        end else if (mode == CPG_M_RETRIG) begin
                           state_r <= CPG_S_WAIT;
                        end else if (mode == CPG_M_GROW) begin
                           curDelay_r <= curDelay_r + {24'h00_0000, incr_r};
                           state_r    <= CPG_S_WAIT;
                        end else begin
                           state_r <= CPG_S_DONE;
                        end
                     end else begin
                        cnt_r <= cnt_r - 32'h0000_0001;
                     end
                  end
               end
               CPG_S_LOW: begin
                  if (srcEdge && !pauseNow) begin
                     if (cnt_r <= 32'h0000_0001) begin
                        tcPulse <= 1'b1;
                        cnt_r   <= high_r;
                        state_r <= CPG_S_HIGH;
                     end else begin
                        cnt_r <= cnt_r - 32'h0000_0001;
                     end
                  end
               end
               CPG_S_DONE: begin
                  state_r <= CPG_S_DONE;
               end
               default: state_r <= CPG_S_IDLE;
            endcase
         end
      end
   end

   // Internal first counter of the finite train: one pulse of twice delay_r source edges.
   logic [31:0] finCnt_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         finGate_r <= 1'b0;
         finCnt_r  <= 32'h0000_0000;
      end else if (!armed_r || !ctrl_r[CPG_CTRL_FINITE]) begin
         finGate_r <= 1'b0;
         finCnt_r  <= 32'h0000_0000;
      end else if (state_r == CPG_S_IDLE) begin
         finGate_r <= 1'b1;
         finCnt_r  <= delay_r + high_r * 32'(0) + delay_r;
      end else if (finGate_r && srcEdge) begin
         finCnt_r <= finCnt_r - 32'h0000_0001;
         if (finCnt_r <= 32'h0000_0001) begin
            finGate_r <= 1'b0;
         end
      end
   end

   // Output level: pulse mode shows the high phase, toggle mode flips at each terminal count.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_r <= 1'b0;
      end else if (!armed_r) begin
         level_r <= 1'b0;
      end else if (ctrl_r[CPG_CTRL_TOGGLE]) begin
         level_r <= level_r ^ tcPulse;
      end else begin
         level_r <= (state_r == CPG_S_HIGH);
      end
   end

   cpg_square_gen cpg_square_gen_i (
      .clk      (clk),
      .rst_n    (rst_n),
      .enable   (fgen_r[CPG_FGEN_EN]),
      .slowBase (fgen_r[CPG_FGEN_SLOWTB]),
      .divCode  (fgen_r[CPG_FGEN_DIV_LSB +: 4]),
      .waveOut  (sqWave)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         counterOut                   <= 1'b0;
         terminal_count_event         <= 1'b0;
         square_wave_generator_out    <= 1'b0;
         sampleClkDo                  <= 1'b0;
         sampleClkDi                  <= 1'b0;
         programmable_function_pin    <= 3'h0;
         programmable_function_pin_oe <= 3'h0;
      end else begin
         counterOut                   <= level_r ^ ctrl_r[CPG_CTRL_INVERT];
         terminal_count_event         <= tcPulse;
         square_wave_generator_out    <= sqWave;
         sampleClkDo                  <= sqWave;
         sampleClkDi                  <= sqWave;
         programmable_function_pin    <= {sqWave, gateIn,
                                          level_r ^ ctrl_r[CPG_CTRL_INVERT]};
         programmable_function_pin_oe <= pinEn_r;
      end
   end

   // Assertions.
   a_pins_off_reset: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> programmable_function_pin_oe == 3'h0)
      else $error("pins driven at reset");
   a_idle_unarmed: assert property (@(posedge clk) disable iff (!rst_n)
      !armed_r |=> state_r == CPG_S_IDLE)
      else $error("engine ran while unarmed");
   a_edge_only: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == CPG_S_DELAY && !srcEdge && armed_r && !disarmCmd) |=> $stable(cnt_r))
      else $error("count moved without source edge");
   a_gate_ignored: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == CPG_S_DONE && armed_r && !disarmCmd) |=> state_r == CPG_S_DONE)
      else $error("trigger mode retriggered");
   a_delay_to_high: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == CPG_S_DELAY && srcEdge && cnt_r == 32'h1 && mode != CPG_M_TRAIN
       && armed_r && !disarmCmd) |=> state_r == CPG_S_HIGH ##0 tcPulse)
      else $error("delay end did not start pulse");
   a_train_low: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == CPG_S_HIGH && srcEdge && cnt_r == 32'h1 && mode == CPG_M_TRAIN
       && !pauseNow && armed_r && !disarmCmd) |=> state_r == CPG_S_LOW && cnt_r == low_r)
      else $error("train missed low phase");
   a_retrig_wait: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == CPG_S_HIGH && srcEdge && cnt_r == 32'h1 && mode == CPG_M_RETRIG
       && armed_r && !disarmCmd) |=> state_r == CPG_S_WAIT)
      else $error("retrigger did not rewait");
   a_pause_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == CPG_S_LOW && pauseNow && armed_r && !disarmCmd) |=> $stable(cnt_r))
      else $error("pause did not hold train");
   a_grow_step: assert property (@(posedge clk) disable iff (!rst_n)
      (state_r == CPG_S_HIGH && srcEdge && cnt_r == 32'h1 && mode == CPG_M_GROW
       && armed_r && !disarmCmd) |=> curDelay_r == $past(curDelay_r) + {24'h0, $past(incr_r)})
      else $error("delay did not grow");
endmodule : cpg_counter_pulse

/* core/cpg_pkg.sv */
package cpg_pkg;
   // Register byte offsets on the APB bus.
   localparam logic [7:0] CPG_OFF_CTRL     = 8'h00;
   localparam logic [7:0] CPG_OFF_DELAY    = 8'h04;
   localparam logic [7:0] CPG_OFF_HIGH     = 8'h08;
   localparam logic [7:0] CPG_OFF_LOW      = 8'h0c;
   localparam logic [7:0] CPG_OFF_INCR     = 8'h10;
   localparam logic [7:0] CPG_OFF_FGEN     = 8'h14;
   localparam logic [7:0] CPG_OFF_STATUS   = 8'h18;
   localparam logic [7:0] CPG_OFF_CMD      = 8'h1c;
   localparam logic [7:0] CPG_OFF_PINS     = 8'h20;
   // Control, command and FGEN register fields, and reset values.
   localparam int CPG_CTRL_MODE_LSB  = 0;
   localparam int CPG_CTRL_SRCFALL   = 3;
   localparam int CPG_CTRL_TOGGLE    = 4;
   localparam int CPG_CTRL_INVERT    = 5;
   localparam int CPG_CTRL_STARTTRIG = 6;
   localparam int CPG_CTRL_PAUSE     = 7;
   localparam int CPG_CTRL_PAUSELVL  = 8;
   localparam int CPG_CTRL_GATEFALL  = 9;
   localparam int CPG_CTRL_HWARM     = 10;
   localparam int CPG_CTRL_FINITE    = 11;
   localparam int CPG_CMD_ARM        = 0;
   localparam int CPG_CMD_DISARM     = 1;
   localparam int CPG_FGEN_DIV_LSB   = 0;
   localparam int CPG_FGEN_SLOWTB    = 4;
   localparam int CPG_FGEN_EN        = 5;
   localparam logic [31:0] CPG_RST_CTRL  = 32'h0000_0000;
   localparam logic [31:0] CPG_RST_COUNT = 32'h0000_0001;
   localparam logic [7:0]  CPG_RST_INCR  = 8'h00;
   localparam logic [5:0]  CPG_RST_FGEN  = 6'h00;
   localparam logic [2:0]  CPG_RST_PINS  = 3'h0;
   // Timebase rates for the square-wave generator.
   localparam int CPG_CLK_HZ     = 40_000_000;
   localparam int CPG_FAST_TB_HZ = 20_000_000 / 2;
   localparam int CPG_SLOW_TB_HZ = 100_000;
   localparam int CPG_FAST_DIV   = CPG_CLK_HZ / CPG_FAST_TB_HZ;
   localparam int CPG_SLOW_DIV   = CPG_CLK_HZ / CPG_SLOW_TB_HZ;
   typedef enum logic [2:0] {
      CPG_M_SINGLE, CPG_M_TRIG, CPG_M_RETRIG, CPG_M_TRAIN, CPG_M_GROW
   } cpg_mode_t;
   typedef enum logic [2:0] {
      CPG_S_IDLE, CPG_S_WAIT, CPG_S_DELAY, CPG_S_HIGH, CPG_S_LOW, CPG_S_DONE
   } cpg_state_t;
endpackage : cpg_pkg

/* core/cpg_square_gen.sv */
module cpg_square_gen
   import cpg_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Configuration.
   input  wire logic       enable,
   input  wire logic       slowBase,
   input  wire logic [3:0] divCode,
   // Output.
   output logic            waveOut
);
   logic [11:0] preCnt_r;
   logic        tick;
   logic [4:0]  phase_r;
   logic [4:0]  divVal;
   logic [4:0]  lowLen;

   // Timebase is a one-cycle enable, so the generator stays in the main clock domain.
   assign tick   = (preCnt_r == 12'h000);
   assign divVal = {1'b0, divCode} + 5'h01;
   assign lowLen = (divVal == 5'h01) ? 5'h01 : 5'((divVal + 5'h01) >> 1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         preCnt_r <= 12'h000;
      end else if (tick || !enable) begin
         preCnt_r <= slowBase ? 12'(CPG_SLOW_DIV - 1) : 12'(CPG_FAST_DIV - 1);
      end else begin
         preCnt_r <= preCnt_r - 12'h001;
      end
   end

   // Divide by one leaves no tick to count, so the wave follows the halves of the prescaler.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= 5'h00;
         waveOut <= 1'b0;
      end else if (!enable) begin
         phase_r <= 5'h00;
         waveOut <= 1'b0;
      end else if (divVal == 5'h01) begin
         phase_r <= 5'h00;
         waveOut <= (preCnt_r < 12'((slowBase ? CPG_SLOW_DIV : CPG_FAST_DIV) / 2));
      end else if (tick) begin
         phase_r <= (phase_r + 5'h01 >= divVal) ? 5'h00 : phase_r + 5'h01;
         waveOut <= ((phase_r + 5'h01 >= divVal) ? 5'h00 : phase_r + 5'h01) >= lowLen;
      end
   end
endmodule : cpg_square_gen

/* test/counter_pulse_generator_bench.sv */
module counter_pulse_generator_bench
   import cpg_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst_n, psel, penable, pwrite, gateFire, armFire;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdData;
   logic        pready, pslverr, rdErr, counterOut, termCount, sqOut, smpDo, smpDi;
   logic        countSource, gateIn, hwArm;
   logic [2:0]  pins, pinsOe;
   int          n_mismatch, checks, n, d1, d2;
   int          dd[3];
   logic [31:0] fg[4] = '{32'h20, 32'h23, 32'h24, 32'h31};
   int          hi[4] = '{2, 8, 8, 400};
   int          lo[4] = '{2, 8, 12, 400};
   cpg_counter_pulse cpg_counter_pulse_i (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .countSource(countSource), .gateIn(gateIn),
      .hardware_arm_input(hwArm), .counterOut(counterOut), .terminal_count_event(termCount),
      .square_wave_generator_out(sqOut), .sampleClkDo(smpDo), .sampleClkDi(smpDi),
      .programmable_function_pin(pins), .programmable_function_pin_oe(pinsOe));
   cpg_signal_source cpg_signal_source_i (.clk(clk), .rst_n(rst_n), .gateFire(gateFire),
      .armFire(armFire), .countSource(countSource), .gateIn(gateIn),
      .hardware_arm_input(hwArm));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : give_verdict
   task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: word %h, expected %h", $time, got, exp);
      end
   endtask : cmpWord
   task automatic cmpCount(input int got, input int exp);
      checks++;
      if (got != exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: count %0d, expected %0d", $time, got, exp);
      end
   endtask : cmpCount
   // Every wait is bounded; a required level that never comes ends the run.
   task automatic waitSig(input int sel, input logic lvl, input int lim, input bit must,
                          output int cnt);
      logic s;
      cnt = -1;
      for (int k = 1; k <= lim && cnt < 0; k++) begin
         @(posedge clk);
         #1;
         s = (sel == 0) ? counterOut : (sel == 1) ? sqOut : (sel == 2) ? gateIn : termCount;
         if (s === lvl) cnt = k;
      end
      if (cnt < 0 && must) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: output level never came", $time);
         give_verdict();
      end
   endtask : waitSig
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      rdData = prdata;
      rdErr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (i >= 20) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: bus answer missing", $time);
         give_verdict();
      end
   endtask : apb
   task automatic pulseIn(input bit g);
      @(posedge clk);
      if (g) gateFire <= 1'b1;
      else armFire <= 1'b1;
      @(posedge clk);
      gateFire <= 1'b0;
      armFire  <= 1'b0;
   endtask : pulseIn
   task automatic rearm(input logic [31:0] ctrl);
      apb(1'b1, CPG_OFF_CMD, 32'h2);
      apb(1'b1, CPG_OFF_CTRL, ctrl);
      apb(1'b1, CPG_OFF_CMD, 32'h1);
   endtask : rearm
   initial begin
      {psel, penable, pwrite, gateFire, armFire} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_mismatch = 0;
      checks = 0;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      cmpWord({29'h0, pinsOe}, 32'h0);
      apb(1'b1, CPG_OFF_PINS, 32'h7);
      apb(1'b0, CPG_OFF_CTRL, 32'h0);
      cmpWord(rdData, CPG_RST_CTRL);
      cmpWord({29'h0, pinsOe}, 32'h7);
      apb(1'b0, CPG_OFF_DELAY, 32'h0);
      cmpWord(rdData, CPG_RST_COUNT);
      apb(1'b0, 8'h40, 32'h0);
      cmpWord({rdData[31:1], rdErr}, 32'h1);
      // Single pulse: nothing before arming, then one pulse of three periods.
      apb(1'b1, CPG_OFF_DELAY, 32'h4);
      apb(1'b1, CPG_OFF_HIGH, 32'h3);
      waitSig(0, 1'b1, 100, 0, n);
      cmpCount(n, -1);
      apb(1'b1, CPG_OFF_CMD, 32'h1);
      waitSig(0, 1'b1, 500, 1, n);
      waitSig(0, 1'b0, 500, 1, n);
      cmpCount(n, 24);
      waitSig(0, 1'b1, 200, 0, n);
      cmpCount(n, -1);
      // Pulse train armed by the hardware arm input.
      apb(1'b1, CPG_OFF_CMD, 32'h2);
      apb(1'b1, CPG_OFF_HIGH, 32'h2);
      apb(1'b1, CPG_OFF_LOW, 32'h3);
      apb(1'b1, CPG_OFF_CTRL, 32'h403);
      waitSig(0, 1'b1, 100, 0, n);
      cmpCount(n, -1);
      pulseIn(1'b0);
      waitSig(0, 1'b1, 500, 1, n);
      waitSig(0, 1'b0, 100, 1, n);
      cmpCount(n, 16);
      waitSig(0, 1'b1, 100, 1, n);
      cmpCount(n, 24);
      waitSig(0, 1'b0, 100, 1, d1);
      cmpCount(n + d1, 40);
      // Triggered pulse; a second trigger must be disregarded.
      apb(1'b1, CPG_OFF_DELAY, 32'h2);
      rearm(32'h1);
      pulseIn(1'b1);
      waitSig(2, 1'b1, 100, 1, n);
      waitSig(0, 1'b1, 200, 1, d1);
      waitSig(0, 1'b0, 100, 1, n);
      cmpCount(n, 16);
      pulseIn(1'b1);
      waitSig(0, 1'b1, 300, 0, n);
      cmpCount(n, -1);
      // Falling gate fires a source period later; falling source adds half a period.
      rearm(32'h209);
      pulseIn(1'b1);
      waitSig(2, 1'b1, 100, 1, n);
      waitSig(0, 1'b1, 200, 1, d2);
      cmpCount(d2 - d1, 12);
      // Retriggerable: a gate during the pulse is ignored.
      rearm(32'h2);
      for (int k = 0; k < 2; k++) begin
         pulseIn(1'b1);
         waitSig(0, 1'b1, 300, 1, n);
         cmpWord({30'h0, pins[1:0]}, 32'h1);
         if (k == 1) pulseIn(1'b1);
         waitSig(0, 1'b0, 100, 1, n);
         cmpCount(n, 16 - 2 * k);
      end
      waitSig(0, 1'b1, 300, 0, n);
      cmpCount(n, -1);
      // Growing delay; a fresh arm restores the base delay.
      apb(1'b1, CPG_OFF_DELAY, 32'h3);
      apb(1'b1, CPG_OFF_INCR, 32'h1ff);
      apb(1'b0, CPG_OFF_INCR, 32'h0);
      cmpWord(rdData, 32'hff);
      apb(1'b1, CPG_OFF_INCR, 32'h2);
      rearm(32'h4);
      for (int k = 0; k < 3; k++) begin
         if (k == 2) rearm(32'h4);
         pulseIn(1'b1);
         waitSig(2, 1'b1, 100, 1, n);
         waitSig(0, 1'b1, 500, 1, dd[k]);
         waitSig(0, 1'b0, 100, 1, n);
      end
      cmpCount(dd[1] - dd[0], 16);
      cmpCount(dd[2], dd[0]);
      // Train on a gate start trigger, with toggled and inverted output.
      rearm(32'h73);
      waitSig(0, 1'b0, 100, 0, n);
      cmpCount(n, -1);
      pulseIn(1'b1);
      waitSig(0, 1'b0, 300, 1, n);
      waitSig(0, 1'b1, 100, 1, n);
      cmpCount(n, 16);
      waitSig(0, 1'b0, 100, 1, n);
      cmpCount(n, 24);
      waitSig(3, 1'b1, 100, 1, n);
      waitSig(3, 1'b1, 100, 1, n);
      cmpCount(n, 24);
      // A gate pulse in the low phase holds one source edge back.
      rearm(32'h83);
      waitSig(0, 1'b1, 200, 1, n);
      waitSig(0, 1'b0, 100, 1, n);
      pulseIn(1'b1);
      waitSig(0, 1'b1, 100, 1, n);
      cmpCount(n, 30);
      rearm(32'h183);
      waitSig(0, 1'b1, 200, 0, n);
      cmpCount(n, -1);
      // Finite train: the internal gate lets one high phase through.
      rearm(32'h803);
      waitSig(0, 1'b1, 200, 1, n);
      waitSig(0, 1'b0, 100, 1, n);
      cmpCount(n, 16);
      waitSig(0, 1'b1, 200, 0, n);
      cmpCount(n, -1);
      // Square wave over the fast and slow timebases, odd and even dividers.
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, CPG_OFF_FGEN, fg[k]);
         waitSig(1, 1'b0, 1000, 1, n);
         waitSig(1, 1'b1, 1000, 1, n);
         cmpWord({29'h0, smpDo, smpDi, pins[2]}, 32'h7);
         waitSig(1, 1'b0, 1000, 1, n);
         cmpCount(n, hi[k]);
         waitSig(1, 1'b1, 1000, 1, n);
         cmpCount(n, lo[k]);
      end
      give_verdict();
   end
endmodule : counter_pulse_generator_bench

/* test/cpg_signal_source.sv */
module cpg_signal_source (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_n,
   // Requests from the bench.
   input  wire logic gateFire,
   input  wire logic armFire,
   // Terminal signals toward the counter.
   output logic      countSource,
   output logic      gateIn,
   output logic      hardware_arm_input
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] phase_r;
   logic       gatePend_r;
   // The source runs free with an eight-clock period, as a timebase would.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_r     <= 2'h0;
         countSource <= 1'b0;
      end else begin
         phase_r <= phase_r + 2'h1;
         if (phase_r == 2'h3) begin
            countSource <= ~countSource;
         end
      end
   end
   // The gate moves midway between rising source edges, so no count races it.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gateIn     <= 1'b0;
         gatePend_r <= 1'b0;
      end else if (phase_r == 2'h3 && countSource) begin
         gateIn     <= gatePend_r;
         gatePend_r <= gateFire;
      end else if (gateFire) begin
         gatePend_r <= 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hardware_arm_input <= 1'b0;
      end else begin
         hardware_arm_input <= armFire;
      end
   end
endmodule : cpg_signal_source
